// file: core/wdt_consts.vh
// Purpose: constants of the watchdog timer unit
// Assumes: 32-bit AXI4-Lite register bus, byte addresses
// Notes:   definitions only
`ifndef WDT_CONSTS_VH
`define WDT_CONSTS_VH
`define WD_CTRL_OFFS      16'h0034
`define WD_KEY_OFFS       16'h0038
`define WD_STAT_OFFS      16'h0040
`define WD_MASK_OFFS      16'h0044
`define WD_SYS_OFFS       16'h0048
`define WD_CTRL_RESET     8'h09
`define WD_RUN_BIT        3
`define WD_PER_LO         1
`define WD_ACT_BIT        0
`define WD_KEY_CLEAR      8'h4E
`define WD_KEY_DISABLE    8'hB1
`define WD_BASE_EXP       25
`define WD_RST_MIN_CYC    8
`define WD_RST_MAX_CYC    24
`define WD_RST_CYC        5'h10
`endif

// file: core/watchdog_timer_unit.v
// Purpose: watchdog timer with keyed disable, one-time action select, reset pulse
// Assumes: AXI4-Lite slave, one clock, synchronous active-high reset
// Notes:   control registers read as zero; status/mask/system regs readable
// Contract
// - Run bit comes out of reset set, counting starts at once.
// - Stop needs run bit cleared, then key 4E, then disable code B1.
// - Disable code written while run bit is set is ignored.
// - Disabling clears the binary counter to zero.
// - Period field selects 2^25 down to 2^19 cycles; divider bit doubles.
// - Action bit 0 picks interrupt, 1 picks reset; resets to 1.
// - Once action bit is cleared, writes of one are ignored until reset.
// - Primary control register is write-only; software writes whole bytes.
// - Watchdog interrupt request ignores the interrupt enable register.
// - New watchdog interrupt waits until earlier handler's return completes.
// - Reset response drives open-drain reset pin low about 8 to 24 cycles.
// - Clearing the counter leaves the upstream divider untouched.
// - Response fires on the falling edge of the selected top counter bit.
// - Counter pauses in STOP and IDLE, resumes from held value.
//
// Our own choice: the AXI4-Lite slave port.
`timescale 1ns/10ps
`include "wdt_consts.vh"
module watchdog_timer_unit #(
  parameter integer CNT_W    = 27,
  parameter integer BASE_EXP = `WD_BASE_EXP
)(
  input  wire        clk,
  input  wire        srst,
  input  wire [15:0] s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output wire [1:0]  s_axi_bresp,
  output wire        s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [15:0] s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output wire [31:0] s_axi_rdata,
  output wire [1:0]  s_axi_rresp,
  output wire        s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire        stop_mode,
  input  wire        idle_mode,
  input  wire        nmi_return_done,
  input  wire        reset_pin_in,
  output wire        reset_pin_out,
  output wire        reset_pin_oe_n,
  output wire        watchdog_overflow_irq,
  output wire        irq
);

  localparam [1:0] RESP_OKAY   = 2'b00;
  localparam [1:0] RESP_SLVERR = 2'b10;
  localparam [7:0] CTRL_RST    = `WD_CTRL_RESET;

  // Write and read channel capture
  reg  [15:0] awaddr_ff;
  reg         aw_full_ff;
  reg  [31:0] wdata_ff;
  reg  [3:0]  wstrb_ff;
  reg         w_full_ff;
  reg         bvalid_ff;
  reg  [1:0]  bresp_ff;
  reg  [31:0] rdata_ff;
  reg         rvalid_ff;
  reg  [1:0]  rresp_ff;

  // Watchdog state
  reg         run_ff;
  reg  [1:0]  period_ff;
  reg         action_ff;
  reg         action_lock_ff;
  reg         key_seen_ff;
  reg         stopped_ff;
  reg         div_sel_ff;
  reg  [CNT_W-1:0] cnt_ff;
  reg         top_ff;
  reg  [4:0]  rst_cnt_ff;
  reg         pend_ff;
  reg         busy_ff;
  reg  [1:0]  stat_ff;
  reg  [1:0]  mask_ff;
  reg         pin_s1_ff;
  reg         pin_s2_ff;
  reg         stop_s1_ff;
  reg         stop_s2_ff;
  reg         idle_s1_ff;
  reg         idle_s2_ff;
  reg         ret_s1_ff;
  reg         ret_s2_ff;

  function [4:0] exp_sel;
    input [1:0] per;
    input       dv;
    begin
      exp_sel = BASE_EXP[4:0] - {2'b00, per, 1'b0} + {4'b0000, dv};
    end
  endfunction

  function hit;
    input [15:0] a;
    input [15:0] offs;
    begin
      hit = (a[15:2] == offs[15:2]);
    end
  endfunction

  wire       wr_go   = aw_full_ff && w_full_ff && !bvalid_ff;
  wire       wr_ctrl = wr_go && hit(awaddr_ff, `WD_CTRL_OFFS) && wstrb_ff[0];
  wire       wr_key  = wr_go && hit(awaddr_ff, `WD_KEY_OFFS) && wstrb_ff[0];
  wire       wr_stat = wr_go && hit(awaddr_ff, `WD_STAT_OFFS) && wstrb_ff[0];
  wire       wr_mask = wr_go && hit(awaddr_ff, `WD_MASK_OFFS) && wstrb_ff[0];
  wire       wr_sys  = wr_go && hit(awaddr_ff, `WD_SYS_OFFS) && wstrb_ff[0];
  wire       wr_ok   = hit(awaddr_ff, `WD_CTRL_OFFS) || hit(awaddr_ff, `WD_KEY_OFFS)
                    || hit(awaddr_ff, `WD_STAT_OFFS) || hit(awaddr_ff, `WD_MASK_OFFS)
                    || hit(awaddr_ff, `WD_SYS_OFFS);
  wire [7:0] wbyte   = wdata_ff[7:0];

  // Key and disable code only act on their exact values
  wire key_clear  = wr_key && (wbyte == `WD_KEY_CLEAR);
  wire key_dis    = wr_key && (wbyte == `WD_KEY_DISABLE);
  wire disable_go = key_dis && key_seen_ff && !run_ff;
  wire active     = !stopped_ff;
  wire paused     = stop_s2_ff || idle_s2_ff;
  wire [4:0] exp_now = exp_sel(period_ff, div_sel_ff);
  wire cnt_top    = cnt_ff[exp_now - 5'd1];
  wire overflow   = top_ff && !cnt_top && active;

  // Bus handshakes
  assign s_axi_awready = !aw_full_ff;
  assign s_axi_wready  = !w_full_ff;
  assign s_axi_bvalid  = bvalid_ff;
  assign s_axi_bresp   = bresp_ff;
  assign s_axi_arready = !rvalid_ff;
  assign s_axi_rvalid  = rvalid_ff;
  assign s_axi_rdata   = rdata_ff;
  assign s_axi_rresp   = rresp_ff;

  always @(posedge clk)
  begin
    if (srst)
    begin
      aw_full_ff <= 1'b0;
      w_full_ff  <= 1'b0;
      awaddr_ff  <= 16'h0000;
      wdata_ff   <= 32'h0000_0000;
      wstrb_ff   <= 4'h0;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && !aw_full_ff)
      begin
        aw_full_ff <= 1'b1;
        awaddr_ff  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_full_ff)
      begin
        w_full_ff <= 1'b1;
        wdata_ff  <= s_axi_wdata;
        wstrb_ff  <= s_axi_wstrb;
      end
      if (wr_go)
      begin
        aw_full_ff <= 1'b0;
        w_full_ff  <= 1'b0;
        bvalid_ff  <= 1'b1;
        bresp_ff   <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end
      else if (bvalid_ff && s_axi_bready)
        bvalid_ff <= 1'b0;
    end
  end

  // Control registers are write-only and read back as zero
  always @(posedge clk)
  begin
    if (srst)
    begin
      rvalid_ff <= 1'b0;
      rdata_ff  <= 32'h0000_0000;
      rresp_ff  <= RESP_OKAY;
    end
    else if (s_axi_arvalid && !rvalid_ff)
    begin
      rvalid_ff <= 1'b1;
      rresp_ff  <= RESP_OKAY;
      if (hit(s_axi_araddr, `WD_STAT_OFFS))
        rdata_ff <= {30'h0000_0000, stat_ff};
      else if (hit(s_axi_araddr, `WD_MASK_OFFS))
        rdata_ff <= {30'h0000_0000, mask_ff};
      else if (hit(s_axi_araddr, `WD_SYS_OFFS))
        rdata_ff <= {28'h0, pin_s2_ff, stopped_ff, pend_ff, div_sel_ff};
      else if (hit(s_axi_araddr, `WD_CTRL_OFFS) || hit(s_axi_araddr, `WD_KEY_OFFS))
        rdata_ff <= 32'h0000_0000;
      else
      begin
        rdata_ff <= 32'h0000_0000;
        rresp_ff <= RESP_SLVERR;
      end
    end
    else if (rvalid_ff && s_axi_rready)
      rvalid_ff <= 1'b0;
  end

  // Control fields
  always @(posedge clk)
  begin
    if (srst)
    begin
      run_ff         <= CTRL_RST[`WD_RUN_BIT];
      period_ff      <= CTRL_RST[`WD_PER_LO+1:`WD_PER_LO];
      action_ff      <= CTRL_RST[`WD_ACT_BIT];
      action_lock_ff <= 1'b0;
      key_seen_ff    <= 1'b0;
      stopped_ff     <= 1'b0;
      div_sel_ff     <= 1'b0;
    end
    else
    begin
      if (wr_ctrl)
      begin
        run_ff    <= wbyte[`WD_RUN_BIT];
        period_ff <= wbyte[`WD_PER_LO+1:`WD_PER_LO];
        if (wbyte[`WD_RUN_BIT])
          stopped_ff <= 1'b0;
        if (!wbyte[`WD_ACT_BIT])
        begin
          action_ff      <= 1'b0;
          action_lock_ff <= 1'b1;
        end
        else if (!action_lock_ff)
          action_ff <= 1'b1;
      end
      if (wr_key)
        key_seen_ff <= (wbyte == `WD_KEY_CLEAR);
      if (disable_go)
        stopped_ff <= 1'b1;
      if (wr_sys)
        div_sel_ff <= wbyte[0];
    end
  end

  // Binary counter; the upstream divider is elsewhere and never cleared here
  always @(posedge clk)
  begin
    if (srst)
    begin
      cnt_ff <= {CNT_W{1'b0}};
      top_ff <= 1'b0;
    end
    else if (disable_go || (key_clear && active))
    begin
      cnt_ff <= {CNT_W{1'b0}};
      top_ff <= 1'b0;
    end
    else if (active && !paused)
    begin
      cnt_ff <= cnt_ff + {{(CNT_W-1){1'b0}}, 1'b1};
      top_ff <= cnt_top;
    end
  end

  // Reset pulse on the open-drain pin
  always @(posedge clk)
  begin
    if (srst)
      rst_cnt_ff <= 5'd0;
    else if (overflow && action_ff && rst_cnt_ff == 5'd0)
      rst_cnt_ff <= `WD_RST_CYC;
    else if (rst_cnt_ff != 5'd0)
      rst_cnt_ff <= rst_cnt_ff - 5'd1;
  end

  assign reset_pin_out  = 1'b0;
  assign reset_pin_oe_n = (rst_cnt_ff == 5'd0);

  // Pseudo non-maskable request, held while a handler runs
  wire ret_done = ret_s2_ff;
  always @(posedge clk)
  begin
    if (srst)
    begin
      pend_ff <= 1'b0;
      busy_ff <= 1'b0;
    end
    else
    begin
      if (overflow && !action_ff)
        pend_ff <= 1'b1;
      else if (pend_ff && !busy_ff)
        pend_ff <= 1'b0;
      if (pend_ff && !busy_ff)
        busy_ff <= 1'b1;
      else if (ret_done)
        busy_ff <= 1'b0;
    end
  end

  assign watchdog_overflow_irq = pend_ff && !busy_ff;

  // Sticky status: bit0 interrupt overflow, bit1 reset overflow
  wire [1:0] ev = {overflow && action_ff, overflow && !action_ff};
  always @(posedge clk)
  begin
    if (srst)
    begin
      stat_ff <= 2'b00;
      mask_ff <= 2'b00;
    end
    else
    begin
      stat_ff <= (stat_ff & ~(wr_stat ? wbyte[1:0] : 2'b00)) | ev;
      if (wr_mask)
        mask_ff <= wbyte[1:0];
    end
  end

  assign irq = |(stat_ff & mask_ff);

  // Asynchronous inputs pass two flops
  always @(posedge clk)
  begin
    if (srst)
    begin
      pin_s1_ff  <= 1'b1;
      pin_s2_ff  <= 1'b1;
      stop_s1_ff <= 1'b0;
      stop_s2_ff <= 1'b0;
      idle_s1_ff <= 1'b0;
      idle_s2_ff <= 1'b0;
      ret_s1_ff  <= 1'b0;
      ret_s2_ff  <= 1'b0;
    end
    else
    begin
      pin_s1_ff  <= reset_pin_in;
      pin_s2_ff  <= pin_s1_ff;
      stop_s1_ff <= stop_mode;
      stop_s2_ff <= stop_s1_ff;
      idle_s1_ff <= idle_mode;
      idle_s2_ff <= idle_s1_ff;
      ret_s1_ff  <= nmi_return_done;
      ret_s2_ff  <= ret_s1_ff;
    end
  end

endmodule // watchdog_timer_unit

// file: tb/wdt_monitor.sv
// Purpose: port-level assertions for the watchdog timer unit
// Assumes: single clock, srst synchronous active high
// Notes:   bound from the testbench top file
`timescale 1ns/10ps
module wdt_monitor #(
  parameter integer BASE_EXP = 12
)(
  input wire logic        clk,
  input wire logic        srst,
  input wire logic [15:0] s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        stop_mode,
  input wire logic        idle_mode,
  input wire logic        reset_pin_oe_n,
  input wire logic        watchdog_overflow_irq
);
  reg [4:0]  low_ff;
  reg [2:0]  pause_ff;
  reg [15:0] age_ff;
  // Counters keep long waits out of the properties; pause_ff and age_ff saturate, low_ff wraps
  always @(posedge clk)
  begin
    low_ff   <= reset_pin_oe_n ? 5'h00 : low_ff + 5'h01;
    pause_ff <= !(stop_mode | idle_mode) ? 3'h0 : pause_ff + {2'h0, pause_ff != 3'h7};
    age_ff   <= srst ? 16'h0000 : age_ff + {15'h0000, age_ff != 16'hFFFF};
  end
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  sequence pin_drop;
    $fell(reset_pin_oe_n);
  endsequence
  sequence ctrl_read;
    s_axi_arvalid && s_axi_arready && s_axi_araddr == 16'h0034;
  endsequence
  chk_pulse_min: assert property (pin_drop |-> !reset_pin_oe_n [*8])
    else $error("reset pulse too short");
  chk_pulse_max: assert property (low_ff <= 5'h18)
    else $error("reset pulse too long");
  chk_reset_quiet: assert property ($fell(srst) |-> reset_pin_oe_n && !watchdog_overflow_irq)
    else $error("response active after reset");
  chk_no_early: assert property (pin_drop |-> age_ff >= (16'h0001 << (BASE_EXP - 6)))
    else $error("overflow too early");
  chk_pause_pin: assert property (pause_ff == 3'h7 |-> !$fell(reset_pin_oe_n))
    else $error("reset pulse while paused");
  chk_pause_irq: assert property (pause_ff == 3'h7 |-> !$rose(watchdog_overflow_irq))
    else $error("interrupt while paused");
  chk_ctrl_zero: assert property (ctrl_read |=> s_axi_rvalid && s_axi_rdata == 32'h00000000)
    else $error("control register read nonzero");
  chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
endmodule // wdt_monitor

// file: tb/test_watchdog_timer_unit.sv
// Purpose: self-checking bench for the watchdog timer unit
// Assumes: shortened count exponent, pull-up on the reset pin
// Notes:   bus tasks sample handshakes half a cycle before each edge
`timescale 1ns/10ps
module test_watchdog_timer_unit;
  localparam integer EXP = 12;
  reg         clk = 1'b0;
  reg         srst = 1'b1;
  reg  [15:0] s_axi_awaddr = 16'h0000, s_axi_araddr = 16'h0000;
  reg  [31:0] s_axi_wdata = 32'h00000000, rd_q;
  reg  [3:0]  s_axi_wstrb = 4'hF;
  // Response readies stay high, so no call re-raises them at the edge that dropped them
  reg         s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b1;
  reg         s_axi_arvalid = 1'b0, s_axi_rready = 1'b1, stop_mode = 1'b0;
  reg         idle_mode = 1'b0, nmi_return_done = 1'b0;
  reg  [1:0]  resp_q;
  wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire        reset_pin_oe_n, reset_pin_out, watchdog_overflow_irq, irq;
  wire [1:0]  s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  // Pull-up: the pin reads high once released
  wire        reset_pin_in = reset_pin_oe_n ? 1'b1 : reset_pin_out;
  integer     err_count = 0, n_checks = 0, cyc = 0, t_pin, t_irq, low_n, p, c, d;
  watchdog_timer_unit #(.BASE_EXP(EXP)) dut_u (.clk, .srst, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .stop_mode, .idle_mode, .nmi_return_done,
    .reset_pin_in, .reset_pin_out, .reset_pin_oe_n, .watchdog_overflow_irq, .irq);
  always #2.5 clk = ~clk;
  task stop_test;
  begin
    $display("checks %0d, errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  end
  endtask
  always @(posedge clk)
  begin
    cyc = cyc + 1;
    if (cyc == 40000)
    begin
      err_count = err_count + 1;
      stop_test;
    end
  end
  task chk(input [31:0] g, input [31:0] e);
  begin
    n_checks = n_checks + 1;
    if (g !== e)
    begin
      err_count = err_count + 1;
      $display("Error at %0t: got %h exp %h", $time, g, e);
    end
  end
  endtask
  task chk_in(input integer v, input integer lo, input integer hi);
  begin
    n_checks = n_checks + 1;
    if (v < lo || v > hi)
    begin
      err_count = err_count + 1;
      $display("Error at %0t: got %h exp %h to %h", $time, v, lo, hi);
    end
  end
  endtask
  task chk_irq(input e);
  begin
    @(negedge clk);
    chk({31'h00000000, irq}, {31'h00000000, e});
    @(posedge clk);
  end
  endtask
  task rst;
  begin
    srst <= 1'b1;
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
  end
  endtask
  // Handshake values are stable from the falling edge up to the next rising edge
  task wr(input [15:0] a, input [31:0] v);
    reg ta, tw, tb;
  begin
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    tb = 1'b0;
    while (!tb)
    begin
      @(negedge clk);
      ta = s_axi_awvalid & s_axi_awready;
      tw = s_axi_wvalid & s_axi_wready;
      tb = s_axi_bready & s_axi_bvalid;
      resp_q = s_axi_bresp;
      @(posedge clk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
    end
  end
  endtask
  task rd(input [15:0] a);
    reg ta, tr;
  begin
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    tr = 1'b0;
    while (!tr)
    begin
      @(negedge clk);
      ta = s_axi_arvalid & s_axi_arready;
      tr = s_axi_rready & s_axi_rvalid;
      rd_q = s_axi_rdata;
      resp_q = s_axi_rresp;
      @(posedge clk);
      if (ta) s_axi_arvalid <= 1'b0;
    end
  end
  endtask
  task watch(input integer lim);
    integer i;
  begin
    t_pin = -1;
    t_irq = -1;
    low_n = 0;
    for (i = 0; i < lim; i = i + 1)
    begin
      @(negedge clk);
      if (reset_pin_oe_n === 1'b0 && t_pin < 0) t_pin = i;
      if (reset_pin_oe_n === 1'b0) low_n = low_n + 1;
      if (watchdog_overflow_irq === 1'b1 && t_irq < 0) t_irq = i;
    end
    @(posedge clk);
  end
  endtask
  task test_reset;
  begin
    rst;
    rd(16'h0034);
    chk(rd_q, 32'h00000000);
    rd(16'h003C);
    chk({30'h00000000, resp_q}, 32'h00000002);
    p = 1 << EXP;
    watch(p + 24);
    chk_in(t_pin, p - 10, p + 6);
    chk_in(low_n, 16, 16);
    chk_in(t_irq, -1, -1);
    rd(16'h0040);
    chk(rd_q, 32'h00000002);
    chk({31'h00000000, reset_pin_out}, 32'h00000000);
    wr(16'h003C, 32'h00000000);
    chk({30'h00000000, resp_q}, 32'h00000002);
    wr(16'h0040, 32'h00000002);
    chk({30'h00000000, resp_q}, 32'h00000000);
    rd(16'h0040);
    chk(rd_q, 32'h00000000);
    rd(16'h0048);
    chk(rd_q & 32'h00000008, 32'h00000008);
    $display("reset test done");
  end
  endtask
  task test_period;
  begin
    for (c = 1; c < 4; c = c + 1)
      for (d = 0; d < 2; d = d + 1)
      begin
        rst;
        wr(16'h0048, d);
        wr(16'h0034, 32'h00000009 | (c << 1));
        wr(16'h0038, 32'h0000004E);
        p = 1 << (EXP - 2 * c + d);
        watch(p + 24);
        chk_in(t_pin, p - 10, p + 6);
        chk_in(low_n, 16, 16);
      end
    $display("period test done");
  end
  endtask
  task test_irq;
  begin
    rst;
    wr(16'h0034, 32'h0000000E);
    wr(16'h0034, 32'h0000000F);
    wr(16'h0038, 32'h0000004E);
    watch(88);
    chk_in(t_irq, 54, 70);
    chk_in(t_pin, -1, -1);
    chk_irq(1'b0);
    wr(16'h0044, 32'h00000001);
    chk_irq(1'b1);
    rd(16'h0040);
    chk(rd_q, 32'h00000001);
    wr(16'h0040, 32'h00000001);
    chk_irq(1'b0);
    // Second overflow falls inside this window while the first handler still runs
    watch(40);
    chk_in(t_irq, -1, -1);
    nmi_return_done <= 1'b1;
    @(posedge clk);
    nmi_return_done <= 1'b0;
    watch(40);
    chk_in(t_pin, -1, -1);
    chk_in(t_irq, 1, 6);
    $display("interrupt test done");
  end
  endtask
  task test_disable;
  begin
    rst;
    wr(16'h0038, 32'h0000004E);
    wr(16'h0038, 32'h000000B1);
    rd(16'h0048);
    chk(rd_q & 32'h00000004, 32'h00000000);
    wr(16'h0034, 32'h00000001);
    wr(16'h0038, 32'h0000004E);
    // Long gap, so a disable that keeps the count shifts the next overflow
    watch(2000);
    wr(16'h0038, 32'h000000B1);
    rd(16'h0048);
    chk(rd_q & 32'h00000004, 32'h00000004);
    p = 1 << EXP;
    watch(p + 24);
    chk_in(t_pin, -1, -1);
    wr(16'h0034, 32'h00000009);
    watch(p + 24);
    chk_in(t_pin, p - 10, p + 6);
    $display("disable test done");
  end
  endtask
  task test_kick;
  begin
    rst;
    wr(16'h0034, 32'h0000000F);
    for (c = 0; c < 4; c = c + 1)
    begin
      wr(16'h0038, 32'h0000004E);
      watch(48);
      chk_in(t_pin, -1, -1);
    end
    $display("kick test done");
  end
  endtask
  task test_pause;
  begin
    for (c = 0; c < 2; c = c + 1)
    begin
      rst;
      wr(16'h0034, 32'h0000000F);
      wr(16'h0038, 32'h0000004E);
      watch(20);
      if (c == 0) idle_mode <= 1'b1;
      else stop_mode <= 1'b1;
      watch(200);
      chk_in(t_pin, -1, -1);
      idle_mode <= 1'b0;
      stop_mode <= 1'b0;
      watch(60);
      chk_in(t_pin, 30, 55);
    end
    $display("pause test done");
  end
  endtask
  initial
  begin
    test_reset;
    test_period;
    test_irq;
    test_disable;
    test_kick;
    test_pause;
    stop_test;
  end
endmodule // test_watchdog_timer_unit
bind watchdog_timer_unit wdt_monitor #(.BASE_EXP(BASE_EXP)) mon_u (.clk, .srst, .s_axi_araddr,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .stop_mode, .idle_mode,
  .reset_pin_oe_n, .watchdog_overflow_irq);
